// ==== sbc_spi_pkg.sv ====
// Shared constants and types for the serial slave and power-down controller.
package sbc_spi_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_FREQ_MHZ      = 10;
  localparam int MCU_RESET_TIME_NS = 10000;
  localparam int MCU_RESET_CYCLES  = (MCU_RESET_TIME_NS * CLK_FREQ_MHZ) / 1000;

  // ********************************************************************
  // Header, status and burst layout
  // ********************************************************************
  localparam logic [3:0] STATUS_MARKER   = 4'hA;
  localparam int         ACCESS_BIT_POS  = 7;
  localparam logic [7:0] BURST_MAX_BYTES = 8'h80;
  localparam int         FIFO_WIDTH      = 16;
  localparam int         FIFO_DEPTH      = 32;

  // ********************************************************************
  // Internally decoded addresses and fields
  // ********************************************************************
  localparam logic [7:0] LOW_POWER_CONFIG_ADDR = 8'h7E;
  localparam logic [7:0] POWERDOWN_CMD_ADDR    = 8'h7F;
  localparam logic [7:0] POWERDOWN_CMD_VALUE   = 8'hA5;
  localparam int         TARGET_FIELD_LSB      = 0;
  localparam logic [1:0] TARGET_RESET          = 2'h0;
  localparam logic [1:0] TARGET_LOW            = 2'h0;
  localparam logic [1:0] TARGET_ULTRA          = 2'h1;
  localparam logic [1:0] TARGET_OFF            = 2'h2;

  typedef enum logic [1:0] {FULL_POWER_STATE, LOW_POWER_STATE, ULTRA_LOW_POWER_STATE, OFF_STATE} power_state_type;
  typedef enum logic [1:0] {PHASE_ADDR, PHASE_LEN, PHASE_DATA} phase_type;

endpackage : sbc_spi_pkg

// ==== sbc_write_fifo.sv ====
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module sbc_write_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;

  wire ptr_same = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire is_full  = ptr_same & (wr_ptr_q[AW] != rd_ptr_q[AW]);
  wire is_empty = ptr_same & (wr_ptr_q[AW] == rd_ptr_q[AW]);
  wire push     = in_valid_in & ~is_full;
  wire pop      = out_ready_in & ~is_empty;

  assign in_ready_out  = ~is_full;
  assign out_valid_out = ~is_empty;
  assign out_data_out  = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
    end
  end

endmodule : sbc_write_fifo

`default_nettype wire

// ==== sbc_spi_slave_powerdown.sv ====
// Serial slave front end, write buffer and power-state controller.
`timescale 1ns/1ps
`default_nettype none

module sbc_spi_slave_powerdown #(
  parameter int FIFO_DEPTH       = sbc_spi_pkg::FIFO_DEPTH,
  parameter int MCU_RESET_CYCLES = sbc_spi_pkg::MCU_RESET_CYCLES
) (
  input  wire logic       MCLK_IN,
  input  wire logic       RST_B_IN,
  input  wire logic       SCLK_IN,
  input  wire logic       CHIP_SELECT_LOW_IN,
  input  wire logic       MOSI_IN,
  output logic            MISO_OUT,
  output logic            MISO_OE_OUT,
  input  wire logic       LOW_VOLTAGE_IN,
  input  wire logic [2:0] RESET_CAUSE_IN,
  input  wire logic       WDT_ACTIVE_IN,
  input  wire logic       LPOSC_TRIM_ACTIVE_IN,
  input  wire logic       VT_ADC_ACTIVE_IN,
  input  wire logic       CUR_ADC_ACTIVE_IN,
  input  wire logic       LIN_SHORT_PROT_IN,
  input  wire logic       LIN_TXD_TIMEOUT_IN,
  input  wire logic       SLEEP_TIMER_VALID_IN,
  input  wire logic       OTP_DOWNLOAD_IN,
  input  wire logic       OTP_SELECT_IN,
  output logic            REG_RD_OUT,
  output logic            OTP_RD_OUT,
  output logic [7:0]      RD_ADDR_OUT,
  input  wire logic [7:0] REG_RDATA_IN,
  input  wire logic [7:0] OTP_RDATA_IN,
  output logic            REG_WR_VALID_OUT,
  input  wire logic       REG_WR_READY_IN,
  output logic [7:0]      REG_WR_ADDR_OUT,
  output logic [7:0]      REG_WR_DATA_OUT,
  output logic            WR_OVERFLOW_OUT,
  input  wire logic       IRQ_ACTIVE_IN,
  input  wire logic       WDT_MCU_RESET_IN,
  input  wire logic       LIN_WAKE_IN,
  output logic [1:0]      POWER_STATE_OUT,
  output logic            PD_REJECTED_OUT,
  output logic            AWAKE_OUT,
  output logic            MCU_SUPPLY_EN_OUT,
  output logic            MCU_RESET_OUT,
  output logic            HP_OSC_EN_OUT,
  output logic            LP_OSC_EN_OUT,
  output logic            CONV_CLK_LP_SEL_OUT,
  output logic            CONV_EN_OUT
);

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic [2:0] sclk_sync_q;
  logic [2:0] cs_sync_q;
  logic [1:0] mosi_sync_q;

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_B_IN)
    begin
      sclk_sync_q <= 3'h7;
      cs_sync_q   <= 3'h7;
      mosi_sync_q <= 2'h0;
    end
    else
    begin
      sclk_sync_q <= {sclk_sync_q[1:0], SCLK_IN};
      cs_sync_q   <= {cs_sync_q[1:0], CHIP_SELECT_LOW_IN};
      mosi_sync_q <= {mosi_sync_q[0], MOSI_IN};
    end
  end

  // ********************************************************************
  // Edge detection and status framing
  // ********************************************************************
  sbc_spi_pkg::phase_type phase_q;
  logic [2:0]  bit_cnt_q;
  logic [7:0]  rx_q;
  logic [7:0]  tx_q;
  logic [7:0]  addr_q;
  logic [7:0]  remaining_q;
  logic        write_q;
  logic        rd_req_q;
  logic        load_q;
  logic        miso_q;
  logic        overflow_q;

  wire         sclk_rise  = sclk_sync_q[1] & ~sclk_sync_q[2];
  wire         sclk_fall  = ~sclk_sync_q[1] & sclk_sync_q[2];
  wire         cs_idle    = cs_sync_q[1];
  wire         cs_rise    = cs_sync_q[1] & ~cs_sync_q[2];
  wire  [7:0]  rx_next    = {rx_q[6:0], mosi_sync_q[1]};
  wire         byte_done  = sclk_rise & ~cs_idle & (bit_cnt_q == 3'h7);
  wire         last_byte  = (remaining_q == 8'h01);
  wire  [6:0]  len_field  = rx_next[6:0];
  wire  [7:0]  burst_len  = (len_field == 7'h00) ? sbc_spi_pkg::BURST_MAX_BYTES : {1'b0, len_field};
  wire         hdr_write  = rx_next[sbc_spi_pkg::ACCESS_BIT_POS];
  wire  [11:0] ssw_now    = {LOW_VOLTAGE_IN, RESET_CAUSE_IN, WDT_ACTIVE_IN, LPOSC_TRIM_ACTIVE_IN,
                             VT_ADC_ACTIVE_IN,
                             CUR_ADC_ACTIVE_IN, LIN_SHORT_PROT_IN, LIN_TXD_TIMEOUT_IN,
                             SLEEP_TIMER_VALID_IN, OTP_DOWNLOAD_IN};
  wire  [15:0] status_frame = {sbc_spi_pkg::STATUS_MARKER, ssw_now};
  wire  [7:0]  rdata_sel  = OTP_SELECT_IN ? OTP_RDATA_IN : REG_RDATA_IN;
  wire         rd_next    = byte_done & (((phase_q == sbc_spi_pkg::PHASE_LEN) & ~hdr_write) |
                            ((phase_q == sbc_spi_pkg::PHASE_DATA) & ~write_q & ~last_byte));
  wire         wr_push    = byte_done & (phase_q == sbc_spi_pkg::PHASE_DATA) & write_q;
  wire         fifo_in_ready;

  // ********************************************************************
  // Serial front end
  // ********************************************************************
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_B_IN)
    begin
      phase_q     <= sbc_spi_pkg::PHASE_ADDR;
      bit_cnt_q   <= 3'h0;
      rx_q        <= 8'h00;
      tx_q        <= 8'h00;
      addr_q      <= 8'h00;
      remaining_q <= 8'h00;
      write_q     <= 1'b0;
      rd_req_q    <= 1'b0;
      load_q      <= 1'b0;
      miso_q      <= 1'b0;
    end
    else if (cs_idle)
    begin
      phase_q   <= sbc_spi_pkg::PHASE_ADDR;
      bit_cnt_q <= 3'h0;
      rd_req_q  <= 1'b0;
      load_q    <= 1'b0;
      tx_q      <= status_frame[15:8];
    end
    else
    begin
      rd_req_q <= rd_next;
      load_q   <= rd_req_q;
      if (sclk_fall)
      begin
        miso_q <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
      end
      if (sclk_rise)
      begin
        rx_q      <= rx_next;
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      if (byte_done)
      begin
        unique case (phase_q)
          sbc_spi_pkg::PHASE_ADDR:
          begin
            addr_q  <= rx_next;
            phase_q <= sbc_spi_pkg::PHASE_LEN;
            tx_q    <= status_frame[7:0];
          end
          sbc_spi_pkg::PHASE_LEN:
          begin
            write_q     <= hdr_write;
            remaining_q <= burst_len;
            phase_q     <= sbc_spi_pkg::PHASE_DATA;
            tx_q        <= 8'h00;
          end
          sbc_spi_pkg::PHASE_DATA:
          begin
            remaining_q <= remaining_q - 8'h01;
            addr_q      <= addr_q + 8'h01;
            if (last_byte)
            begin
              phase_q <= sbc_spi_pkg::PHASE_ADDR;
              tx_q    <= status_frame[15:8];
            end
            else
            begin
              tx_q <= 8'h00;
            end
          end
          default:
          begin
            phase_q <= sbc_spi_pkg::PHASE_ADDR;
          end
        endcase
      end
      if (load_q)
      begin
        tx_q <= rdata_sel;
      end
    end
  end

  assign MISO_OUT    = miso_q;
  assign MISO_OE_OUT = ~cs_idle;
  assign REG_RD_OUT  = rd_req_q & ~OTP_SELECT_IN;
  assign OTP_RD_OUT  = rd_req_q & OTP_SELECT_IN;
  assign RD_ADDR_OUT = addr_q;

  // ********************************************************************
  // Write buffer and internal decode
  // ********************************************************************
  logic [15:0] fifo_out_data;
  logic        fifo_out_valid;
  logic        fifo_out_ready;

  sbc_write_fifo #(
    .WIDTH (sbc_spi_pkg::FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_write_fifo (
    .clk_in        (MCLK_IN),
    .rst_b_in      (RST_B_IN),
    .in_valid_in   (wr_push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({addr_q, rx_next}),  // Read phase never pushes.
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_out_ready),
    .out_data_out  (fifo_out_data)
  );

  wire [7:0] wr_addr      = fifo_out_data[15:8];
  wire [7:0] wr_data      = fifo_out_data[7:0];
  wire       hit_cfg      = (wr_addr == sbc_spi_pkg::LOW_POWER_CONFIG_ADDR);
  wire       hit_cmd      = (wr_addr == sbc_spi_pkg::POWERDOWN_CMD_ADDR);
  wire       internal_hit = hit_cfg | hit_cmd;
  wire       pop          = fifo_out_valid & fifo_out_ready;
  wire       cmd_seen     = pop & hit_cmd & (wr_data == sbc_spi_pkg::POWERDOWN_CMD_VALUE);

  assign fifo_out_ready   = internal_hit | REG_WR_READY_IN;
  assign REG_WR_VALID_OUT = fifo_out_valid & ~internal_hit;
  assign REG_WR_ADDR_OUT  = wr_addr;
  assign REG_WR_DATA_OUT  = wr_data;

  always_ff @(posedge MCLK_IN)
  begin
    overflow_q <= RST_B_IN & (overflow_q | (wr_push & ~fifo_in_ready));
  end

  assign WR_OVERFLOW_OUT = overflow_q;

  // ********************************************************************
  // Power-down controller
  // ********************************************************************
  sbc_spi_pkg::power_state_type pstate_q;
  logic [1:0]  low_power_config_reg_q;
  logic        armed_q;
  logic        rise_pending_q;
  logic        rejected_q;
  logic [15:0] mcu_rst_cnt_q;

  wire       in_full     = (pstate_q == sbc_spi_pkg::FULL_POWER_STATE);
  wire       cmd_accept  = cmd_seen & in_full & ~IRQ_ACTIVE_IN;
  wire       cmd_refuse  = cmd_seen & IRQ_ACTIVE_IN;
  wire       pd_fire     = in_full & armed_q & (rise_pending_q | cs_rise) & ~fifo_out_valid & ~cmd_seen;
  wire       wake_low    = IRQ_ACTIVE_IN | WDT_MCU_RESET_IN;
  wire       wake_ultra  = IRQ_ACTIVE_IN;
  wire       wake_off    = LIN_WAKE_IN;
  wire [1:0] target      = low_power_config_reg_q;
  sbc_spi_pkg::power_state_type pd_dest;

  assign pd_dest = (target == sbc_spi_pkg::TARGET_ULTRA) ? sbc_spi_pkg::ULTRA_LOW_POWER_STATE :
                   (target == sbc_spi_pkg::TARGET_OFF) ? sbc_spi_pkg::OFF_STATE : sbc_spi_pkg::LOW_POWER_STATE;
  wire       start_reset = ((pstate_q == sbc_spi_pkg::ULTRA_LOW_POWER_STATE) & wake_ultra) |
                           ((pstate_q == sbc_spi_pkg::OFF_STATE) & wake_off);

  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_B_IN)
    begin
      pstate_q               <= sbc_spi_pkg::FULL_POWER_STATE;
      low_power_config_reg_q <= sbc_spi_pkg::TARGET_RESET;
      armed_q                <= 1'b0;
      rise_pending_q         <= 1'b0;
      rejected_q             <= 1'b0;
    end
    else
    begin
      if (pop & hit_cfg)
      begin
        low_power_config_reg_q <= wr_data[sbc_spi_pkg::TARGET_FIELD_LSB +: 2];
      end
      rejected_q     <= cmd_refuse | (rejected_q & ~cmd_accept);
      rise_pending_q <= cs_rise | (rise_pending_q & (fifo_out_valid | cmd_seen));
      armed_q        <= cmd_accept | (armed_q & ~pd_fire);
      unique case (pstate_q)
        sbc_spi_pkg::FULL_POWER_STATE: pstate_q <= pd_fire ? pd_dest : pstate_q;
        sbc_spi_pkg::LOW_POWER_STATE: pstate_q <= wake_low ? sbc_spi_pkg::FULL_POWER_STATE : pstate_q;
        sbc_spi_pkg::ULTRA_LOW_POWER_STATE:
        begin
          pstate_q <= wake_ultra ? sbc_spi_pkg::FULL_POWER_STATE : pstate_q;
        end
        sbc_spi_pkg::OFF_STATE: pstate_q <= wake_off ? sbc_spi_pkg::FULL_POWER_STATE : pstate_q;
      endcase
    end
  end

  // ********************************************************************
  // Controller reset stretcher
  // ********************************************************************
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_B_IN)
    begin
      mcu_rst_cnt_q <= 16'h0000;
    end
    else if (start_reset)
    begin
      mcu_rst_cnt_q <= 16'(MCU_RESET_CYCLES);
    end
    else if (mcu_rst_cnt_q != 16'h0000)
    begin
      mcu_rst_cnt_q <= mcu_rst_cnt_q - 16'h0001;
    end
  end

  // ********************************************************************
  // State-dependent outputs
  // ********************************************************************
  wire st_low   = (pstate_q == sbc_spi_pkg::LOW_POWER_STATE);
  wire st_ultra = (pstate_q == sbc_spi_pkg::ULTRA_LOW_POWER_STATE);
  wire st_off   = (pstate_q == sbc_spi_pkg::OFF_STATE);

  assign POWER_STATE_OUT     = pstate_q;
  assign PD_REJECTED_OUT     = rejected_q;
  assign AWAKE_OUT           = in_full | st_low;
  assign MCU_SUPPLY_EN_OUT   = in_full | st_low;
  assign MCU_RESET_OUT       = (mcu_rst_cnt_q != 16'h0000) | st_ultra | st_off;
  assign HP_OSC_EN_OUT       = in_full;
  assign LP_OSC_EN_OUT       = ~st_off;
  assign CONV_CLK_LP_SEL_OUT = st_low | st_ultra;
  assign CONV_EN_OUT         = ~st_off;

endmodule : sbc_spi_slave_powerdown

`default_nettype wire

// ==== sbc_spi_slave_powerdown_sva.sv ====
// Port-level assertions for the serial slave and power-down controller.
`timescale 1ns/1ps
`default_nettype none

module sbc_spi_slave_powerdown_chk #(
  parameter int MCU_RESET_CYCLES = 4
) (
  input wire logic       MCLK_IN,
  input wire logic       RST_B_IN,
  input wire logic       CHIP_SELECT_LOW_IN,
  input wire logic       MISO_OE_OUT,
  input wire logic       OTP_SELECT_IN,
  input wire logic       REG_RD_OUT,
  input wire logic       OTP_RD_OUT,
  input wire logic       IRQ_ACTIVE_IN,
  input wire logic       WDT_MCU_RESET_IN,
  input wire logic       LIN_WAKE_IN,
  input wire logic [1:0] POWER_STATE_OUT,
  input wire logic       PD_REJECTED_OUT,
  input wire logic       MCU_RESET_OUT,
  input wire logic       MCU_SUPPLY_EN_OUT,
  input wire logic       HP_OSC_EN_OUT,
  input wire logic       CONV_CLK_LP_SEL_OUT
);
  int unsigned rst_cnt_q;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_B_IN);

  sequence s_cs_fall;
    $fell(CHIP_SELECT_LOW_IN);
  endsequence
  sequence s_cs_idle;
    CHIP_SELECT_LOW_IN [*4];
  endsequence
  sequence s_rd_req;
    REG_RD_OUT || OTP_RD_OUT;
  endsequence

  // Counts full-power cycles in which the controller is still held in reset.
  always_ff @(posedge MCLK_IN)
  begin
    if (!RST_B_IN || !MCU_RESET_OUT || POWER_STATE_OUT != 2'h0)
      rst_cnt_q <= 0;
    else
      rst_cnt_q <= rst_cnt_q + 1;
  end

  chk_oe_on_select: assert property (s_cs_fall |-> ##[1:4] MISO_OE_OUT)
    else $error("serial output not enabled after select");
  chk_oe_off_idle: assert property (s_cs_idle |-> !MISO_OE_OUT)
    else $error("serial output enabled while deselected");
  chk_rd_source: assert property ((REG_RD_OUT || OTP_RD_OUT) && $stable(OTP_SELECT_IN)
    |-> OTP_RD_OUT == OTP_SELECT_IN && REG_RD_OUT == !OTP_SELECT_IN)
    else $error("read request sent to the wrong store");
  chk_rd_one_pulse: assert property (s_rd_req |=> !REG_RD_OUT && !OTP_RD_OUT)
    else $error("read request longer than one cycle");
  chk_pd_reject: assert property ($rose(PD_REJECTED_OUT) |-> $past(IRQ_ACTIVE_IN))
    else $error("command refused without an active interrupt");
  chk_pd_entry: assert property ($changed(POWER_STATE_OUT) && POWER_STATE_OUT != 2'h0
    |-> $past(POWER_STATE_OUT) == 2'h0 && CHIP_SELECT_LOW_IN)
    else $error("low state entered without deselect from full power");
  chk_wake_low: assert property (POWER_STATE_OUT == 2'h1 && (IRQ_ACTIVE_IN || WDT_MCU_RESET_IN)
    |=> POWER_STATE_OUT == 2'h0 && !MCU_RESET_OUT)
    else $error("low state did not wake cleanly");
  chk_wake_ultra: assert property (POWER_STATE_OUT == 2'h2 && IRQ_ACTIVE_IN
    |=> POWER_STATE_OUT == 2'h0 && MCU_RESET_OUT)
    else $error("ultra-low state did not wake with reset");
  chk_wake_off: assert property (POWER_STATE_OUT == 2'h3
    |=> POWER_STATE_OUT == ($past(LIN_WAKE_IN) ? 2'h0 : 2'h3))
    else $error("off state left by the wrong source");
  chk_osc_select: assert property (HP_OSC_EN_OUT == (POWER_STATE_OUT == 2'h0)
    && CONV_CLK_LP_SEL_OUT == (POWER_STATE_OUT inside {2'h1, 2'h2}))
    else $error("converter clock source wrong for state");
  chk_supply_cut: assert property (POWER_STATE_OUT[1] |-> MCU_RESET_OUT && !MCU_SUPPLY_EN_OUT)
    else $error("controller supplied in a deep state");
  chk_reset_len: assert property ($fell(MCU_RESET_OUT) |-> rst_cnt_q == MCU_RESET_CYCLES)
    else $error("controller reset length wrong after wake");
endmodule : sbc_spi_slave_powerdown_chk
`default_nettype wire

// ==== sbc_mcu_master.sv ====
// Behavioural serial master standing in for the external controller.
`timescale 1ns/1ps
`default_nettype none

module sbc_mcu_master #(
  parameter int HALF = 6
) (
  input  wire logic clk_in,
  output logic      sclk_out,
  output logic      cs_low_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  initial
  begin
    sclk_out = 1'b1;
    cs_low_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Changes select only with the clock idle high; a released data line flips.
  task automatic select(input logic on);
    repeat (HALF) @(negedge clk_in);
    cs_low_out = !on;
    if (!on)
      mosi_out = !mosi_out;
    repeat (HALF) @(negedge clk_in);
  endtask : select

  // Shifts on the falling edge and samples just before the rising edge.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge clk_in);
      sclk_out = 1'b0;
      mosi_out = tx[i];
      repeat (HALF - 1) @(negedge clk_in);
      rx[i] = miso_in;
      sclk_out = 1'b1;
      repeat (HALF - 1) @(negedge clk_in);
    end
  endtask : xfer
endmodule : sbc_mcu_master
`default_nettype wire

// ==== sbc_spi_slave_powerdown_tb_top.sv ====
// Self-checking testbench for the serial slave and power-down controller.
`timescale 1ns/1ps
`default_nettype none

module sbc_spi_slave_powerdown_tb_top;
  localparam int RST_CYC = 4;
  localparam logic [6:0] PINS [4] = '{7'h6D, 7'h67, 7'h17, 7'h10};
  localparam logic [1:0] TGT [4] = '{sbc_spi_pkg::TARGET_ULTRA, sbc_spi_pkg::TARGET_LOW,
                                     sbc_spi_pkg::TARGET_ULTRA, sbc_spi_pkg::TARGET_OFF};
  logic        mclk = 1'b0;
  logic        rst_b, otp_sel, irq, wdt_rst, lin_wake, wr_ready, sclk, cs_low, mosi, miso, miso_oe;
  logic        reg_rd, otp_rd, wr_valid, ovf, rej, awake, sup_en, mcu_rst, hp_osc, lp_osc, lp_sel, conv_en;
  logic [11:0] slave_status_word = 12'h5C3;
  logic [7:0]  rd_addr, wr_addr, wr_data, rx, reg_rdata = 8'h00, otp_rdata = 8'h00;
  logic [1:0]  pstate;
  int          err_count = 0;
  int          check_count = 0;

  always #50 mclk = !mclk;

  // Register file and one-time memory answer on the falling clock edge after the request.
  always @(negedge mclk)
  begin
    if (reg_rd)
      reg_rdata <= rd_addr ^ 8'h3C;
    if (otp_rd)
      otp_rdata <= ~rd_addr;
  end

  sbc_spi_slave_powerdown #(.MCU_RESET_CYCLES(RST_CYC)) i_sbc_spi_slave_powerdown (
    .MCLK_IN(mclk), .RST_B_IN(rst_b), .SCLK_IN(sclk), .CHIP_SELECT_LOW_IN(cs_low), .MOSI_IN(mosi),
    .MISO_OUT(miso), .MISO_OE_OUT(miso_oe), .LOW_VOLTAGE_IN(slave_status_word[11]), .RESET_CAUSE_IN(slave_status_word[10:8]),
    .WDT_ACTIVE_IN(slave_status_word[7]), .LPOSC_TRIM_ACTIVE_IN(slave_status_word[6]), .VT_ADC_ACTIVE_IN(slave_status_word[5]),
    .CUR_ADC_ACTIVE_IN(slave_status_word[4]), .LIN_SHORT_PROT_IN(slave_status_word[3]), .LIN_TXD_TIMEOUT_IN(slave_status_word[2]),
    .SLEEP_TIMER_VALID_IN(slave_status_word[1]), .OTP_DOWNLOAD_IN(slave_status_word[0]), .OTP_SELECT_IN(otp_sel),
    .REG_RD_OUT(reg_rd), .OTP_RD_OUT(otp_rd), .RD_ADDR_OUT(rd_addr), .REG_RDATA_IN(reg_rdata),
    .OTP_RDATA_IN(otp_rdata), .REG_WR_VALID_OUT(wr_valid), .REG_WR_READY_IN(wr_ready),
    .REG_WR_ADDR_OUT(wr_addr), .REG_WR_DATA_OUT(wr_data), .WR_OVERFLOW_OUT(ovf), .IRQ_ACTIVE_IN(irq),
    .WDT_MCU_RESET_IN(wdt_rst), .LIN_WAKE_IN(lin_wake), .POWER_STATE_OUT(pstate), .PD_REJECTED_OUT(rej),
    .AWAKE_OUT(awake), .MCU_SUPPLY_EN_OUT(sup_en), .MCU_RESET_OUT(mcu_rst), .HP_OSC_EN_OUT(hp_osc),
    .LP_OSC_EN_OUT(lp_osc), .CONV_CLK_LP_SEL_OUT(lp_sel), .CONV_EN_OUT(conv_en));

  sbc_mcu_master i_sbc_mcu_master (
    .clk_in(mclk), .sclk_out(sclk), .cs_low_out(cs_low), .mosi_out(mosi), .miso_in(miso));

  task automatic finish_test();
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic header(input logic [7:0] addr, input logic [7:0] len_byte);
    i_sbc_mcu_master.xfer(addr, rx);
    check("status high", {4'hA, slave_status_word[11:8]}, rx);
    i_sbc_mcu_master.xfer(len_byte, rx);
    check("status low", slave_status_word[7:0], rx);
  endtask : header

  task automatic rd_burst(input logic [7:0] addr, input logic [6:0] len);
    int n;
    n = (len == 7'h00) ? 128 : int'(len);
    header(addr, {1'b0, len});
    for (int i = 0; i < n; i++)
    begin
      i_sbc_mcu_master.xfer(8'hFF - 8'(i), rx);
      check("read data", otp_sel ? ~(addr + 8'(i)) : (addr + 8'(i)) ^ 8'h3C, rx);
    end
  endtask : rd_burst

  task automatic wr_burst(input logic [7:0] addr, input logic [7:0] data, input int n);
    header(addr, {1'b1, 7'(n)});
    for (int i = 0; i < n; i++)
    begin
      i_sbc_mcu_master.xfer(data + 8'(i), rx);
      check("write echo", 8'h00, rx);
    end
  endtask : wr_burst

  initial
  begin
    {rst_b, otp_sel, irq, wdt_rst, lin_wake, wr_ready} = 6'h00;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    @(negedge mclk);
    check("state pins", {1'b0, PINS[0]}, {1'b0, awake, sup_en, mcu_rst, hp_osc, lp_osc, lp_sel, conv_en});
    i_sbc_mcu_master.select(1'b1);
    i_sbc_mcu_master.xfer(8'h10, rx);
    check("address only", {4'hA, slave_status_word[11:8]}, rx);
    i_sbc_mcu_master.select(1'b0);
    check("oe idle", 8'h00, {7'h00, miso_oe});
    i_sbc_mcu_master.select(1'b1);
    check("oe selected", 8'h01, {7'h00, miso_oe});
    rd_burst(8'hFE, 7'h03);
    otp_sel = 1'b1;
    rd_burst(8'h80, 7'h00);
    otp_sel = 1'b0;
    wr_burst(8'h40, 8'h90, 33);
    i_sbc_mcu_master.select(1'b0);
    check("overflow", 8'h01, {7'h00, ovf});
    for (int i = 0; i < 32; i++)
    begin
      check("write valid", 8'h01, {7'h00, wr_valid});
      check("write addr", 8'h40 + 8'(i), wr_addr);
      check("write data", 8'h90 + 8'(i), wr_data);
      wr_ready = 1'b1;
      @(negedge mclk);
      wr_ready = 1'b0;
      @(negedge mclk);
    end
    check("buffer empty", 8'h00, {7'h00, wr_valid});
    wr_ready = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      slave_status_word = ~slave_status_word;
      irq = (k == 0);
      i_sbc_mcu_master.select(1'b1);
      wr_burst(sbc_spi_pkg::LOW_POWER_CONFIG_ADDR, {6'h00, TGT[k]}, 1);
      wr_burst(sbc_spi_pkg::POWERDOWN_CMD_ADDR, sbc_spi_pkg::POWERDOWN_CMD_VALUE, 1);
      i_sbc_mcu_master.select(1'b0);
      repeat (10) @(negedge mclk);
      check("entered state", 8'(k), {6'h00, pstate});
      check("refused", (k == 0) ? 8'h01 : 8'h00, {7'h00, rej});
      check("state pins", {1'b0, PINS[k]}, {1'b0, awake, sup_en, mcu_rst, hp_osc, lp_osc, lp_sel, conv_en});
      if (k == 3)
      begin
        irq = 1'b1;
        @(negedge mclk);
        irq = 1'b0;
        @(negedge mclk);
        check("off ignores irq", 8'h03, {6'h00, pstate});
      end
      wdt_rst = (k == 1);
      irq = (k == 2);
      lin_wake = (k == 3);
      @(negedge mclk);
      wdt_rst = 1'b0;
      irq = 1'b0;
      lin_wake = 1'b0;
      @(negedge mclk);
      check("woken", 8'h00, {6'h00, pstate});
      check("mcu reset held", (k >= 2) ? 8'h01 : 8'h00, {7'h00, mcu_rst});
      repeat (RST_CYC) @(negedge mclk);
      check("mcu reset done", 8'h00, {7'h00, mcu_rst});
    end
    finish_test();
  end

  initial
  begin
    repeat (60000) @(posedge mclk);
    err_count++;
    finish_test();
  end
endmodule : sbc_spi_slave_powerdown_tb_top

bind sbc_spi_slave_powerdown sbc_spi_slave_powerdown_chk #(.MCU_RESET_CYCLES(MCU_RESET_CYCLES)) i_chk (
  .MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN), .CHIP_SELECT_LOW_IN(CHIP_SELECT_LOW_IN), .MISO_OE_OUT(MISO_OE_OUT),
  .OTP_SELECT_IN(OTP_SELECT_IN), .REG_RD_OUT(REG_RD_OUT), .OTP_RD_OUT(OTP_RD_OUT),
  .IRQ_ACTIVE_IN(IRQ_ACTIVE_IN), .WDT_MCU_RESET_IN(WDT_MCU_RESET_IN), .LIN_WAKE_IN(LIN_WAKE_IN),
  .POWER_STATE_OUT(POWER_STATE_OUT), .PD_REJECTED_OUT(PD_REJECTED_OUT), .MCU_RESET_OUT(MCU_RESET_OUT),
  .MCU_SUPPLY_EN_OUT(MCU_SUPPLY_EN_OUT), .HP_OSC_EN_OUT(HP_OSC_EN_OUT), .CONV_CLK_LP_SEL_OUT(CONV_CLK_LP_SEL_OUT));
`default_nettype wire
